// ---- hw/nvm_access_defs.svh ----
// offsets, field positions, reset values and timing counts of the nvm access block
`ifndef NVM_ACCESS_DEFS_SVH
`define NVM_ACCESS_DEFS_SVH

// i/o register offsets (6-bit i/o space)
`define NVM_OFS_ADDR_LOW 6'h1e
`define NVM_OFS_ADDR_HIGH 6'h1f
`define NVM_OFS_BYTE_BUFFER 6'h1d
`define NVM_OFS_CONTROL 6'h1c

// control register field positions
`define NVM_CTRL_MODE_HI 5
`define NVM_CTRL_MODE_LO 4
`define NVM_CTRL_IRQ_ENABLE 3
`define NVM_CTRL_ARM 2
`define NVM_CTRL_GO_BUSY 1
`define NVM_CTRL_READ 0

// mode reset value and erased byte value
`define NVM_MODE_RESET 2'h0
`define NVM_ERASED_BYTE 8'hff

// timing
`define NVM_CLK_PERIOD_NS 50
`define NVM_ATOMIC_TIME_NS 3400000
`define NVM_SPLIT_TIME_NS 1800000
`define NVM_ATOMIC_CYCLES ((`NVM_ATOMIC_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)
`define NVM_SPLIT_CYCLES ((`NVM_SPLIT_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)
`define NVM_ARM_HOLD 2'h3
`define NVM_PROG_STALL 3'h1
`define NVM_READ_STALL 3'h3
`define NVM_TIMER_BITS 17

`endif

// ---- hw/nvm_access_pkg.sv ----
// types shared by the nvm access block
package nvm_access_pkg;

    // programming mode field encoding
    typedef enum logic [1:0] {
        MODE_ATOMIC,
        MODE_ERASE,
        MODE_WRITE,
        MODE_RESERVED
    } prog_mode_type;

    // controller state
    typedef struct packed {
        logic [8:0] pointer;
        logic [7:0] buffer;
        prog_mode_type mode;
        logic irqEnable;
        logic arm;
        logic [1:0] armLeft;
        logic [2:0] stallLeft;
        logic cpuStall;
        logic readyIrq;
        logic [7:0] rdData;
    } ctrl_state_type;

    // programming timer state
    typedef struct packed {
        logic busy;
        logic done;
        logic [16:0] count;
    } timer_state_type;

    // pending cell operation
    typedef struct packed {
        prog_mode_type mode;
        logic [8:0] addr;
        logic [7:0] data;
    } cell_op_type;

endpackage

// ---- hw/nvm_prog_timer.sv ----
// cycle counter that times one programming operation
`include "nvm_access_defs.svh"

module nvm_prog_timer
(
    // clock and power-on reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic [`NVM_TIMER_BITS-1:0] cycles,
    // status
    output logic busy,
    output logic done
);

    nvm_access_pkg::timer_state_type state;
    nvm_access_pkg::timer_state_type next_state;

    // load on start, count down, pulse done on the last cycle
    always_comb
    begin
        next_state = state;
        next_state.done = 1'b0;
        if (start && !state.busy)
        begin
            next_state.busy = 1'b1;
            next_state.count = cycles - `NVM_TIMER_BITS'(1);
        end
        else if (state.busy)
        begin
            if (state.count == '0)
            begin
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
            end
            else
            begin
                next_state.count = state.count - `NVM_TIMER_BITS'(1);
            end
        end
    end

    // only power-on clears it, so a running operation survives reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign busy = state.busy;
    assign done = state.done;

endmodule // nvm_prog_timer

// ---- hw/nvm_cell_array.sv ----
// byte storage with erase, write and atomic update committed at end of operation
`include "nvm_access_defs.svh"

module nvm_cell_array
(
    // clock and power-on reset
    input wire logic clk,
    input wire logic reset,
    // operation
    input wire logic start,
    input wire nvm_access_pkg::prog_mode_type mode,
    input wire logic [8:0] addr,
    input wire logic [7:0] data,
    input wire logic commit,
    // read port
    input wire logic [8:0] readAddr,
    output logic [7:0] readData
);

    logic [7:0] cells [0:511];
    nvm_access_pkg::cell_op_type op;
    nvm_access_pkg::cell_op_type next_op;

    // latch the operation when it starts; later register writes do not alter it
    always_comb
    begin
        next_op = op;
        if (start)
        begin
            next_op.mode = mode;
            next_op.addr = addr;
            next_op.data = data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            op <= '0;
        end
        else
        begin
            op <= next_op;
        end
    end

    // write-only can only clear bits, so an unerased cell ends up mixed
    always_ff @(posedge clk)
    begin
        if (commit)
        begin
            unique case (op.mode)
                nvm_access_pkg::MODE_ATOMIC: cells[op.addr] <= op.data;
                nvm_access_pkg::MODE_ERASE: cells[op.addr] <= `NVM_ERASED_BYTE;
                nvm_access_pkg::MODE_WRITE: cells[op.addr] <= cells[op.addr] & op.data;
                default: cells[op.addr] <= cells[op.addr];
            endcase
        end
    end

    assign readData = cells[readAddr];

endmodule // nvm_cell_array

// ---- hw/nvm_access_ctrl.sv ----
// i/o register controller for reading, erasing and programming the on-chip nvm
//
// Operation
// - bytes addressed linearly, unused top bits zero
// - high address bits 7:1 read zero
// - byte buffer holds write data, read data
// - control bits 7 and 6 read zero
// - mode field selects atomic, erase, write
// - mode writes ignored while busy
// - reset clears mode unless still busy
// - ready request held while enabled and ready
// - arm bit self-clears four cycles later
// - go starts only while arm still set
// - busy bit stays set until time elapses
// - start stalls processor two cycles
// - read strobe fetches byte, stalls four
// - busy blocks reads and address changes
// - busy refuses any other operation
// - reset lets running operation finish
// - write without erase leaves undefined contents
`include "nvm_access_defs.svh"

module nvm_access_ctrl
#(
    parameter int CAPACITY = 512,
    parameter int ATOMIC_CYCLES = `NVM_ATOMIC_CYCLES,
    parameter int SPLIT_CYCLES = `NVM_SPLIT_CYCLES
)
(
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic powerOnReset,
    // processor i/o register port
    input wire logic [5:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    // processor status
    input wire logic globalIrqEnable,
    output logic cpuStall,
    output logic readyIrq
);

    nvm_access_pkg::ctrl_state_type state;
    nvm_access_pkg::ctrl_state_type next_state;

    logic progBusy;
    logic progDone;
    logic progStart;
    logic [`NVM_TIMER_BITS-1:0] progCycles;
    logic [7:0] cellData;

    // keep only the address bits that the storage size implements
    function automatic logic [8:0] clipPointer(input logic [8:0] raw);
        logic [8:0] mask;
        mask = 9'h07f;
        if (CAPACITY >= 256)
        begin
            mask[7] = 1'b1;
        end
        if (CAPACITY >= 512)
        begin
            mask[8] = 1'b1;
        end
        return raw & mask;
    endfunction

    // terminal count for the selected mode
    function automatic logic [`NVM_TIMER_BITS-1:0] modeCycles(
        input nvm_access_pkg::prog_mode_type mode);
        if (mode == nvm_access_pkg::MODE_ATOMIC)
        begin
            return `NVM_TIMER_BITS'(ATOMIC_CYCLES);
        end
        return `NVM_TIMER_BITS'(SPLIT_CYCLES);
    endfunction

    // register read view
    function automatic logic [7:0] readView(
        input logic [5:0] addr,
        input nvm_access_pkg::ctrl_state_type s,
        input logic busy);
        logic [7:0] value;
        value = 8'h00;
        unique case (addr)
            `NVM_OFS_ADDR_LOW: value = s.pointer[7:0];
            `NVM_OFS_ADDR_HIGH: value = {7'h00, s.pointer[8]};
            `NVM_OFS_BYTE_BUFFER: value = s.buffer;
            `NVM_OFS_CONTROL: value = controlView(s, busy);
            default: value = 8'h00; // unmapped offsets read zero
        endcase
        return value;
    endfunction

    // control register as the core sees it; the read strobe never reads back
    function automatic logic [7:0] controlView(
        input nvm_access_pkg::ctrl_state_type s,
        input logic busy);
        logic [7:0] value;
        value = 8'h00; // bits 7 and 6 stay zero
        value[`NVM_CTRL_MODE_HI:`NVM_CTRL_MODE_LO] = s.mode;
        value[`NVM_CTRL_IRQ_ENABLE] = s.irqEnable;
        value[`NVM_CTRL_ARM] = s.arm;
        value[`NVM_CTRL_GO_BUSY] = busy;
        value[`NVM_CTRL_READ] = 1'b0;
        return value;
    endfunction

    // address pair write; a smaller part keeps its missing bits at zero
    function automatic logic [8:0] pointerWrite(
        input logic [8:0] pointer,
        input logic low,
        input logic high,
        input logic [7:0] data);
        logic [8:0] value;
        value = pointer;
        if (low)
        begin
            value = clipPointer({pointer[8], data});
        end
        if (high)
        begin
            value = clipPointer({data[0], pointer[7:0]});
        end
        return value;
    endfunction

    // state left by an ordinary reset: a running operation keeps its mode
    function automatic nvm_access_pkg::ctrl_state_type afterReset(
        input nvm_access_pkg::ctrl_state_type s,
        input logic busy);
        nvm_access_pkg::ctrl_state_type r;
        r = '0;
        r.arm = 1'b0; // an armed window does not outlive a reset
        r.cpuStall = 1'b0; // a cut stall frees the core at once
        r.pointer = s.pointer; // undefined after reset anyway
        r.buffer = s.buffer;
        if (busy)
        begin
            r.mode = s.mode;
        end
        else
        begin
            r.mode = nvm_access_pkg::prog_mode_type'(`NVM_MODE_RESET);
        end
        return r;
    endfunction

    // state after power-on: everything idle, mode at its reset code
    function automatic nvm_access_pkg::ctrl_state_type powerOnState();
        nvm_access_pkg::ctrl_state_type r;
        r = '0;
        r.mode = nvm_access_pkg::prog_mode_type'(`NVM_MODE_RESET);
        return r;
    endfunction

    // one register selected by a strobe
    function automatic logic hitsOffset(
        input logic strobe,
        input logic [5:0] addr,
        input logic [5:0] ofs);
        return strobe && addr == ofs;
    endfunction

    // write decode
    logic wrLow;
    logic wrHigh;
    logic wrBuffer;
    logic wrControl;
    logic goRequest;
    logic readRequest;

    // qualified requests
    logic armWrite;
    logic addrWritable;
    logic modeWritable;
    logic readAccepted;

    assign wrLow = hitsOffset(ioWrite, ioAddr, `NVM_OFS_ADDR_LOW);
    assign wrHigh = hitsOffset(ioWrite, ioAddr, `NVM_OFS_ADDR_HIGH);
    assign wrBuffer = hitsOffset(ioWrite, ioAddr, `NVM_OFS_BYTE_BUFFER);
    assign wrControl = hitsOffset(ioWrite, ioAddr, `NVM_OFS_CONTROL);
    assign goRequest = wrControl && ioWrData[`NVM_CTRL_GO_BUSY];
    assign readRequest = wrControl && ioWrData[`NVM_CTRL_READ];

    // a running operation freezes the address pair and the mode field
    assign addrWritable = !progBusy;
    assign modeWritable = !progBusy;
    assign armWrite = wrControl && ioWrData[`NVM_CTRL_ARM];

    // go wins over a read strobe in the same write, whether the go is taken or not
    assign readAccepted = readRequest && !ioWrData[`NVM_CTRL_GO_BUSY]
        && !progBusy;

    // reserved mode never starts; arm must still be set, nothing busy, no reset
    assign progStart = goRequest && state.arm && !progBusy && !reset
        && state.mode != nvm_access_pkg::MODE_RESERVED;
    assign progCycles = modeCycles(state.mode);

    // next state of the controller
    always_comb
    begin
        next_state = state;

        // address pair is frozen during programming
        next_state.pointer = pointerWrite(state.pointer, wrLow && addrWritable,
            wrHigh && addrWritable, ioWrData);

        // the buffer is free to change; the cell array took its copy at start
        if (wrBuffer)
        begin
            next_state.buffer = ioWrData;
        end

        // control register fields
        if (wrControl)
        begin
            next_state.irqEnable = ioWrData[`NVM_CTRL_IRQ_ENABLE];
            if (modeWritable)
            begin
                next_state.mode = nvm_access_pkg::prog_mode_type'(
                    ioWrData[`NVM_CTRL_MODE_HI:`NVM_CTRL_MODE_LO]);
            end
        end

        // arm window: set by software, dropped by hardware after four cycles
        if (state.arm)
        begin
            if (state.armLeft == 2'h0)
            begin
                next_state.arm = 1'b0;
            end
            else
            begin
                next_state.armLeft = state.armLeft - 2'h1;
            end
        end
        if (armWrite)
        begin
            next_state.arm = 1'b1;
            next_state.armLeft = `NVM_ARM_HOLD;
        end

        // a second go inside the same window must not start again
        if (progStart)
        begin
            next_state.arm = 1'b0; // one arm buys one start
        end

        // stall countdown
        if (state.cpuStall)
        begin
            if (state.stallLeft == 3'h0)
            begin
                next_state.cpuStall = 1'b0;
            end
            else
            begin
                next_state.stallLeft = state.stallLeft - 3'h1;
            end
        end

        // start of programming stalls the core
        if (progStart)
        begin
            next_state.cpuStall = 1'b1;
            next_state.stallLeft = `NVM_PROG_STALL;
        end

        // read strobe is refused while programming
        if (readAccepted && !progStart)
        begin
            next_state.buffer = cellData;
            next_state.cpuStall = 1'b1;
            next_state.stallLeft = `NVM_READ_STALL;
        end

        // level request, dropped by clearing the enable or by going busy
        next_state.readyIrq = next_state.irqEnable && globalIrqEnable
            && !progBusy && !progStart;

        // registered read data
        if (ioRead)
        begin
            next_state.rdData = readView(ioAddr, state, progBusy);
        end

        // ordinary reset spares a running operation
        if (reset)
        begin
            next_state = afterReset(state, progBusy);
        end
    end

    // power-on clears everything; ordinary reset is folded into next_state
    always_ff @(posedge clk)
    begin
        if (powerOnReset)
        begin
            state <= powerOnState();
        end
        else
        begin
            state <= next_state;
        end
    end

    // programming duration, reset only at power-on so it runs to the end
    nvm_prog_timer timer
    (
        .clk(clk),
        .reset(powerOnReset),
        .start(progStart),
        .cycles(progCycles),
        .busy(progBusy),
        .done(progDone)
    );

    // storage; commit on done, write-only ands into the old byte
    nvm_cell_array cells
    (
        .clk(clk),
        .reset(powerOnReset),
        .start(progStart),
        .mode(state.mode),
        .addr(state.pointer),
        .data(state.buffer),
        .commit(progDone),
        .readAddr(state.pointer),
        .readData(cellData)
    );

    // outputs straight from flip-flops
    assign ioRdData = state.rdData;
    assign cpuStall = state.cpuStall;
    assign readyIrq = state.readyIrq;

endmodule // nvm_access_ctrl

// ---- sim/nvm_access_ctrl_assertions.sv ----
// port assertions of the nvm access controller
module nvm_access_ctrl_checker
#(
    parameter int CAPACITY = 512
)
(
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic powerOnReset,
    // i/o register port
    input wire logic [5:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    // processor status
    input wire logic globalIrqEnable,
    input wire logic cpuStall,
    input wire logic readyIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || powerOnReset);

    logic ctrlWr;
    logic goWr;
    logic rdWr;
    logic [2:0] armAge;

    // decoded control writes
    assign ctrlWr = ioWrite && ioAddr == 6'h1c;
    assign goWr = ctrlWr && ioWrData[1];
    assign rdWr = ctrlWr && ioWrData[0] && !ioWrData[1];

    // cycles since the last arm write; saturates so a stale arm never looks fresh
    always_ff @(posedge clk)
    begin
        if (reset || powerOnReset)
            armAge <= 3'h7;
        else if (ctrlWr && ioWrData[2])
            armAge <= 3'h0;
        else if (armAge != 3'h7)
            armAge <= armAge + 3'h1;
    end

    property p_prog_stall;
        $rose(cpuStall) && $past(goWr) |-> cpuStall[*2] ##1 !cpuStall;
    endproperty
    a_prog_stall: assert property (p_prog_stall)
        else $error("start stall is not two cycles");

    property p_read_stall;
        $rose(cpuStall) && $past(rdWr) |-> cpuStall[*4] ##1 !cpuStall;
    endproperty
    a_read_stall: assert property (p_read_stall)
        else $error("read stall is not four cycles");

    property p_stall_cause;
        $rose(cpuStall) |-> $past(goWr) || $past(rdWr);
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("stall without a start or read strobe");

    property p_go_refused;
        goWr && !ioWrData[2] && armAge > 3'h3 && !cpuStall |=> !cpuStall;
    endproperty
    a_go_refused: assert property (p_go_refused)
        else $error("start taken after the arm window");

    property p_irq_gie;
        !globalIrqEnable |=> !readyIrq;
    endproperty
    a_irq_gie: assert property (p_irq_gie)
        else $error("ready request with interrupts off");

    property p_irq_off;
        ctrlWr && !ioWrData[3] |-> ##[1:2] !readyIrq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("ready request not removed");

    property p_irq_busy;
        $rose(cpuStall) && $past(goWr) |-> ##1 !readyIrq[*8];
    endproperty
    a_irq_busy: assert property (p_irq_busy)
        else $error("ready request while programming");

    property p_high_read;
        ioRead && ioAddr == 6'h1f |=> (ioRdData >> (CAPACITY == 512)) == 8'h00;
    endproperty
    a_high_read: assert property (p_high_read)
        else $error("high address reserved bits not zero");

    property p_ctrl_read;
        ioRead && ioAddr == 6'h1c |=> ioRdData[7:6] == 2'h0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control bits 7 and 6 not zero");
endmodule // nvm_access_ctrl_checker

bind nvm_access_ctrl nvm_access_ctrl_checker #(.CAPACITY(CAPACITY)) checker_inst (
    .clk(clk), .reset(reset), .powerOnReset(powerOnReset), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .globalIrqEnable(globalIrqEnable), .cpuStall(cpuStall), .readyIrq(readyIrq));

// ---- sim/cpu_model.sv ----
// processor core model issuing i/o register accesses
module cpu_model
(
    // clock and core status
    input wire logic clk,
    input wire logic cpuStall,
    input wire logic [7:0] ioRdData,
    // i/o register port
    output logic [5:0] ioAddr,
    output logic ioWrite,
    output logic ioRead,
    output logic [7:0] ioWrData
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial
    begin
        ioAddr = 6'h00;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioWrData = 8'h00;
    end

    // one access; a halted core issues nothing until its stall ends
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        while (cpuStall === 1'b1)
            @(negedge clk);
        if (a == 6'h1c)
            d[7] = 1'b0;
        ioAddr = a;
        ioWrite = w;
        ioRead = !w;
        ioWrData = d;
        @(negedge clk);
        q = ioRdData;
        if (a == 6'h1c)
            q[7] = 1'b0;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioWrData = ~d;
        ioAddr = ~a;
    endtask
endmodule // cpu_model

// ---- sim/testbench.sv ----
// self-checking bench of the nvm access controller
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ATOM = 40;
    localparam int SPLIT = 20;

    logic clk;
    logic reset;
    logic powerOnReset;
    logic globalIrqEnable;
    logic ioWrite;
    logic ioRead;
    logic cpuStall;
    logic readyIrq;
    logic [5:0] ioAddr;
    logic [7:0] ioWrData;
    logic [7:0] ioRdData;
    logic [7:0] q;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    nvm_access_ctrl #(.CAPACITY(512), .ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLIT)) dut (
        .clk(clk), .reset(reset), .powerOnReset(powerOnReset), .ioAddr(ioAddr),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .globalIrqEnable(globalIrqEnable), .cpuStall(cpuStall), .readyIrq(readyIrq));

    cpu_model cpu (.clk(clk), .cpuStall(cpuStall), .ioRdData(ioRdData), .ioAddr(ioAddr),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard, far above the few hundred cycles the tests take
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        cpu.acc(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [5:0] a);
        cpu.acc(1'b0, a, 8'h00, q);
    endtask

    // address, data, mode, arm, start: the guarded programming sequence
    task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
        wr(6'h1f, {7'h00, a[8]});
        wr(6'h1e, a[7:0]);
        wr(6'h1d, d);
        wr(6'h1c, {2'h0, m, 4'h0});
        wr(6'h1c, {2'h0, m, 4'h4});
        wr(6'h1c, {2'h0, m, 4'h2});
    endtask

    // poll busy with a bound so a stuck busy bit cannot hang the run
    task automatic wait_idle();
        int n = 0;
        rd(6'h1c);
        while (q[1] !== 1'b0 && n < 100)
        begin
            rd(6'h1c);
            n++;
        end
        chk(q & 8'h02, 8'h00);
    endtask

    task automatic rd_cell(input logic [8:0] a, input logic [7:0] exp);
        wait_idle();
        wr(6'h1f, {7'h00, a[8]});
        wr(6'h1e, a[7:0]);
        wr(6'h1c, 8'h01);
        rd(6'h1d);
        chk(q, exp);
    endtask

    // main sequence
    initial
    begin
        reset = 1'b1;
        powerOnReset = 1'b1;
        globalIrqEnable = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        powerOnReset = 1'b0;
        rd(6'h1c);
        chk(q, 8'h00);
        // atomic update, then refused accesses while busy
        prog(2'h0, 9'h1a5, 8'h3c);
        rd(6'h1c);
        chk(q, 8'h02);
        wr(6'h1c, 8'h10);
        wr(6'h1e, 8'h00);
        rd(6'h1c);
        chk(q, 8'h02);
        wr(6'h1c, 8'h01);
        rd(6'h1d);
        chk(q, 8'h3c);
        repeat (16) @(negedge clk);
        rd(6'h1c);
        chk(q, 8'h02);
        wr(6'h1d, 8'h00);
        wait_idle();
        rd(6'h1f);
        chk(q, 8'h01);
        rd(6'h1e);
        chk(q, 8'ha5);
        rd_cell(9'h1a5, 8'h3c);
        // erase is the short time, then write-only
        prog(2'h1, 9'h1a5, 8'h00);
        repeat (24) @(negedge clk);
        rd(6'h1c);
        chk(q, 8'h10);
        rd_cell(9'h1a5, 8'hff);
        prog(2'h2, 9'h1a5, 8'h5a);
        rd_cell(9'h1a5, 8'h5a);
        // reserved mode starts nothing
        prog(2'h3, 9'h003, 8'h11);
        rd(6'h1c);
        chk(q & 8'h02, 8'h00);
        // start one cycle past the arm window, then on its last cycle
        wr(6'h1c, 8'h04);
        rd(6'h1c);
        chk(q, 8'h04);
        repeat (1) @(negedge clk);
        wr(6'h1c, 8'h02);
        rd(6'h1c);
        chk(q, 8'h00);
        wr(6'h1c, 8'h14);
        rd(6'h1c);
        chk(q, 8'h14);
        wr(6'h1c, 8'h12);
        // reset mid-operation leaves mode and busy alone
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        rd(6'h1c);
        chk(q, 8'h12);
        rd_cell(9'h003, 8'hff);
        wr(6'h1c, 8'h20);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        rd(6'h1c);
        chk(q, 8'h00);
        // ready request follows enable and global enable
        wr(6'h1c, 8'h08);
        repeat (2) @(negedge clk);
        chk({7'h00, readyIrq}, 8'h01);
        globalIrqEnable = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, readyIrq}, 8'h00);
        globalIrqEnable = 1'b1;
        wr(6'h1c, 8'h00);
        repeat (2) @(negedge clk);
        chk({7'h00, readyIrq}, 8'h00);
        // ready request drops while programming and returns once it is done
        wr(6'h1d, 8'h11);
        wr(6'h1c, 8'h0c);
        wr(6'h1c, 8'h0a);
        chk({7'h00, readyIrq}, 8'h00);
        wait_idle();
        chk({7'h00, readyIrq}, 8'h01);
        rd_cell(9'h003, 8'h11);
        give_verdict();
    end
endmodule // testbench
